// *** core/pbc_opt_sel.sv ***
// Source selection of option and boot values driven to the processor
`timescale 1ns/1ns
`default_nettype none

module pbc_opt_sel (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sources
    input wire logic soft_select,
    input wire pbc_pkg::pbc_opt_s dip_opt,
    input wire pbc_pkg::pbc_opt_s soft_opt,
    input wire logic [4:0] dip_boot,
    input wire logic [4:0] soft_boot,
    // Applied values
    output var pbc_pkg::pbc_opt_s applied_opt,
    output logic [4:0] applied_boot
);

    pbc_pkg::pbc_opt_s src_opt;
    pbc_pkg::pbc_opt_s nxt_opt;
    logic [4:0] nxt_boot;
    pbc_pkg::pbc_opt_s opt_ff;
    logic [4:0] boot_ff;

    assign src_opt = soft_select ? soft_opt : dip_opt; // RULE_12
    assign nxt_opt = src_opt ^ pbc_pkg::OPT_APPLIED_FLIP; // RULE_20
    assign nxt_boot = soft_select ? soft_boot : dip_boot; // RULE_15

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opt_ff <= pbc_pkg::OPT_APPLIED_FLIP;
            boot_ff <= 5'h00;
        end else begin
            opt_ff <= nxt_opt; // RULE_19
            boot_ff <= nxt_boot;
        end
    end

    assign applied_opt = opt_ff;
    assign applied_boot = boot_ff;

    sequence s_dip_chosen;
        !soft_select;
    endsequence

    sequence s_soft_chosen;
        soft_select;
    endsequence

    a_dip_source: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
        s_dip_chosen |=> applied_opt == ($past(dip_opt) ^ 7'h50)
            && applied_boot == $past(dip_boot))
        else $error("applied values not taken from switches");

    a_soft_source: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
        s_soft_chosen |=> applied_opt == ($past(soft_opt) ^ 7'h50)
            && applied_boot == $past(soft_boot))
        else $error("applied values not taken from soft registers");

    a_invert_fields: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
        ##1 applied_opt.pll_multiplier != $past(src_opt.pll_multiplier)
            && applied_opt.byte_order != $past(src_opt.byte_order)
            && applied_opt.osc_choice == $past(src_opt.osc_choice))
        else $error("multiplier or order encoding wrong");

endmodule

`default_nettype wire

// *** core/pbc_pkg.sv ***
// Shared constants and types for the board control register bank
package pbc_pkg;

    // Register byte offsets inside the host memory window
    localparam logic [7:0] OFS_BOARD_CONTROL = 8'h00;
    localparam logic [7:0] OFS_BOARD_HEALTH = 8'h04;
    localparam logic [7:0] OFS_SOFT_OPTION = 8'h08;
    localparam logic [7:0] OFS_SOFT_BOOT = 8'h0c;
    localparam logic [7:0] OFS_DIP_OPTION = 8'h10;
    localparam logic [7:0] OFS_DIP_BOOT = 8'h14;
    localparam logic [7:0] OFS_APPLIED_OPTION = 8'h18;

    // Control register fields
    localparam int unsigned CTL_NMI_BIT = 7;
    localparam int unsigned CTL_TESTER_IRQ_EN_BIT = 6;
    localparam int unsigned CTL_PROC_IRQ_EN_BIT = 5;
    localparam int unsigned CTL_TESTER_READY_BIT = 4;
    localparam int unsigned CTL_TESTER_IRQ_BIT = 3;
    localparam int unsigned CTL_PROC_IRQ_BIT = 2;
    localparam int unsigned CTL_TESTER_RST_BIT = 1;
    localparam int unsigned CTL_PROC_RST_BIT = 0;
    localparam logic [7:0] CTL_RW_MASK = 8'he3;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Health register fields
    localparam int unsigned HLT_SUPPLY_FAULT_BIT = 6;
    localparam int unsigned HLT_POWERDOWN_BIT = 4;
    localparam int unsigned HLT_LINE_B_BIT = 3;
    localparam int unsigned HLT_LINE_A_BIT = 2;
    localparam int unsigned HLT_IND_B_BIT = 1;
    localparam int unsigned HLT_IND_A_BIT = 0;

    // Option and boot switch layouts
    localparam int unsigned OPT_W = 7;
    localparam int unsigned BOOT_W = 5;
    localparam int unsigned BOOT_SEL_BIT = 7;
    localparam logic [7:0] OPT_MASK = 8'h7f;
    localparam logic [7:0] BOOT_MASK = 8'h1f;
    localparam logic [7:0] SOFT_OPT_RESET = 8'h00;
    localparam logic [7:0] SOFT_BOOT_RESET = 8'h05;
    // Multiplier and byte order read inverted on the applied side
    localparam logic [6:0] OPT_APPLIED_FLIP = 7'h50;

    // Option word, switch encoding, bit 6 down to bit 0
    typedef struct packed {
        logic pll_multiplier;
        logic osc_choice;
        logic byte_order;
        logic emulator_choice;
        logic [2:0] user_options;
    } pbc_opt_s;

    // Board state sensed by the bank
    typedef struct packed {
        logic tester_ready_flag;
        logic tester_irq_flag;
        logic proc_host_irq_flag;
        logic core_supply_fault;
        logic proc_powerdown_flag;
        logic daughter_line_b;
        logic daughter_line_a;
        logic indicator_b_state;
        logic indicator_a_state;
    } pbc_board_s;

endpackage

// *** core/pbc_regs.sv ***
// Byte-wide board control and status register bank for the host window
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE_01: Control bit 7 drives processor non-maskable interrupt while it holds 1.
// RULE_02: Host writes 1 then 0 itself; nothing here self-clears.
// RULE_03: Control bit 6 enables forwarding of the tester interrupt.
// RULE_04: Control bit 5 enables forwarding of the processor host interrupt.
// RULE_05: Host interrupt rises when an enabled source interrupt is active.
// RULE_06: Control bits 4..2 mirror tester ready, tester irq, processor irq.
// RULE_07: Control bits 1 and 0 hold tester and processor in reset.
// RULE_08: Health bit 6 reads 1 when core supply is bad.
// RULE_09: Health bit 4 reads 1 while processor is powered down.
// RULE_10: Health bits 3 and 2 read the two daughterboard lines.
// RULE_11: Health bits 1 and 0 read the two indicator states.
// RULE_12: Soft option bits are ignored unless the source select is 1.
// RULE_13: Soft option bits 6 and 5 pick multiplier and oscillator, read-write.
// RULE_14: Soft option bits 4..0 pick order, emulator and user options.
// RULE_15: Soft boot bit 7 picks switches or soft registers as source.
// RULE_16: Soft boot bits 4..0 are read-write, default 00101.
// RULE_17: Switch option readback shows option switches in bits 6..0.
// RULE_18: Switch boot readback shows boot switches in bits 4..0.
// RULE_19: Applied option readback shows values actually given to processor.
// RULE_20: Applied multiplier and order bits read inverted from switch encoding.
// RULE_21: One byte register per four-byte offset in the host window.
// RULE_22: Unused bits read zero; writes to them or read-only bits ignored.
module pbc_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host register port
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    // Board sense inputs
    input wire pbc_pkg::pbc_board_s board_in,
    input wire pbc_pkg::pbc_opt_s dip_opt,
    input wire logic [4:0] dip_boot,
    // Processor and tester controls
    output logic proc_nonmaskable_irq_ctl,
    output logic tester_reset_ctl,
    output logic proc_reset_ctl,
    output logic host_irq,
    output var pbc_pkg::pbc_opt_s applied_opt,
    output logic [4:0] applied_boot
);

    // Address decode
    logic hit_ctl;
    logic hit_hlt;
    logic hit_sopt;
    logic hit_sboot;
    logic hit_dopt;
    logic hit_dboot;
    logic hit_aopt;
    logic wr_ctl;
    logic wr_sopt;
    logic wr_sboot;
    logic rd_req;

    // Stored registers
    logic [7:0] ctl_ff;
    logic [7:0] soft_opt_ff;
    logic [7:0] soft_boot_ff;
    logic [7:0] rdata_ff;
    logic ack_ff;
    logic host_irq_ff;

    // Next values and read views
    logic [7:0] nxt_ctl;
    logic [7:0] nxt_soft_opt;
    logic [7:0] nxt_soft_boot;
    logic [7:0] nxt_rdata;
    logic nxt_host_irq;
    logic [7:0] ctl_view;
    logic [7:0] hlt_view;
    logic [7:0] rd_mux;
    logic tester_irq_fwd;
    logic proc_irq_fwd;
    logic soft_select;
    pbc_pkg::pbc_opt_s soft_opt;
    // Soft boot bits that keep a written value
    localparam logic [7:0] SBOOT_KEEP = pbc_pkg::BOOT_MASK | (8'h01 << pbc_pkg::BOOT_SEL_BIT);

    // Full byte offset compare; misaligned offsets match nothing
    assign hit_ctl = reg_addr == pbc_pkg::OFS_BOARD_CONTROL; // RULE_21
    assign hit_hlt = reg_addr == pbc_pkg::OFS_BOARD_HEALTH;
    assign hit_sopt = reg_addr == pbc_pkg::OFS_SOFT_OPTION;
    assign hit_sboot = reg_addr == pbc_pkg::OFS_SOFT_BOOT;
    assign hit_dopt = reg_addr == pbc_pkg::OFS_DIP_OPTION;
    assign hit_dboot = reg_addr == pbc_pkg::OFS_DIP_BOOT;
    assign hit_aopt = reg_addr == pbc_pkg::OFS_APPLIED_OPTION;

    assign wr_ctl = reg_req && reg_wr && hit_ctl;
    assign wr_sopt = reg_req && reg_wr && hit_sopt;
    assign wr_sboot = reg_req && reg_wr && hit_sboot;
    assign rd_req = reg_req && !reg_wr;

    // Writable bits only; status positions never stored
    assign nxt_ctl = wr_ctl ? (reg_wdata & pbc_pkg::CTL_RW_MASK) : ctl_ff; // RULE_22
    assign nxt_soft_opt = wr_sopt ? (reg_wdata & pbc_pkg::OPT_MASK) : soft_opt_ff; // RULE_13
    assign nxt_soft_boot = wr_sboot
        ? (reg_wdata & (pbc_pkg::BOOT_MASK | (8'h01 << pbc_pkg::BOOT_SEL_BIT)))
        : soft_boot_ff; // RULE_16

    // Interrupt forwarding through enables
    assign tester_irq_fwd = board_in.tester_irq_flag
        && ctl_ff[pbc_pkg::CTL_TESTER_IRQ_EN_BIT]; // RULE_03
    assign proc_irq_fwd = board_in.proc_host_irq_flag
        && ctl_ff[pbc_pkg::CTL_PROC_IRQ_EN_BIT]; // RULE_04
    assign nxt_host_irq = tester_irq_fwd || proc_irq_fwd; // RULE_05

    // Control view with live status positions
    always_comb begin
        ctl_view = ctl_ff & pbc_pkg::CTL_RW_MASK;
        ctl_view[pbc_pkg::CTL_TESTER_READY_BIT] = board_in.tester_ready_flag; // RULE_06
        ctl_view[pbc_pkg::CTL_TESTER_IRQ_BIT] = board_in.tester_irq_flag;
        ctl_view[pbc_pkg::CTL_PROC_IRQ_BIT] = board_in.proc_host_irq_flag;
    end

    // Health view, undefined bits zero
    always_comb begin
        hlt_view = 8'h00; // RULE_22
        hlt_view[pbc_pkg::HLT_SUPPLY_FAULT_BIT] = board_in.core_supply_fault; // RULE_08
        hlt_view[pbc_pkg::HLT_POWERDOWN_BIT] = board_in.proc_powerdown_flag; // RULE_09
        hlt_view[pbc_pkg::HLT_LINE_B_BIT] = board_in.daughter_line_b; // RULE_10
        hlt_view[pbc_pkg::HLT_LINE_A_BIT] = board_in.daughter_line_a;
        hlt_view[pbc_pkg::HLT_IND_B_BIT] = board_in.indicator_b_state; // RULE_11
        hlt_view[pbc_pkg::HLT_IND_A_BIT] = board_in.indicator_a_state;
    end

    // Read selection; unmapped offsets read zero
    assign rd_mux = hit_ctl ? ctl_view
        : hit_hlt ? hlt_view
        : hit_sopt ? soft_opt_ff
        : hit_sboot ? soft_boot_ff
        : hit_dopt ? {1'b0, dip_opt} // RULE_17
        : hit_dboot ? {3'h0, dip_boot} // RULE_18
        : hit_aopt ? {1'b0, applied_opt} // RULE_19
        : 8'h00; // RULE_22

    assign nxt_rdata = rd_req ? rd_mux : rdata_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_ff <= pbc_pkg::CTL_RESET;
            soft_opt_ff <= pbc_pkg::SOFT_OPT_RESET;
            soft_boot_ff <= pbc_pkg::SOFT_BOOT_RESET; // RULE_16
        end else begin
            ctl_ff <= nxt_ctl; // RULE_02
            soft_opt_ff <= nxt_soft_opt; // RULE_14
            soft_boot_ff <= nxt_soft_boot;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
            ack_ff <= 1'b0;
            host_irq_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            ack_ff <= reg_req; // RULE_21
            host_irq_ff <= nxt_host_irq;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_ack = ack_ff;
    assign host_irq = host_irq_ff;
    assign proc_nonmaskable_irq_ctl = ctl_ff[pbc_pkg::CTL_NMI_BIT]; // RULE_01
    assign tester_reset_ctl = ctl_ff[pbc_pkg::CTL_TESTER_RST_BIT]; // RULE_07
    assign proc_reset_ctl = ctl_ff[pbc_pkg::CTL_PROC_RST_BIT];

    // Source selection toward the processor pins
    assign soft_select = soft_boot_ff[pbc_pkg::BOOT_SEL_BIT]; // RULE_15
    assign soft_opt = soft_opt_ff[6:0];

    pbc_opt_sel u_opt_sel (
        .clk(clk),
        .sys_rst(sys_rst),
        .soft_select(soft_select),
        .dip_opt(dip_opt),
        .soft_opt(soft_opt),
        .dip_boot(dip_boot),
        .soft_boot(soft_boot_ff[4:0]),
        .applied_opt(applied_opt),
        .applied_boot(applied_boot)
    );

    // Checks
    sequence s_ctl_write;
        reg_req && reg_wr && hit_ctl;
    endsequence

    sequence s_ctl_read;
        reg_req && !reg_wr && hit_ctl;
    endsequence

    sequence s_hlt_read;
        reg_req && !reg_wr && hit_hlt;
    endsequence

    sequence s_no_ctl_write;
        !(reg_req && reg_wr && hit_ctl);
    endsequence

    sequence s_sboot_write;
        reg_req && reg_wr && hit_sboot;
    endsequence

    sequence s_sboot_read;
        reg_req && !reg_wr && hit_sboot;
    endsequence

    a_nmi_follows_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
        s_ctl_write |=> proc_nonmaskable_irq_ctl == $past(reg_wdata[7]))
        else $error("nmi does not follow control write");

    a_ctl_holds: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
        s_no_ctl_write |=> $stable(proc_nonmaskable_irq_ctl)
            && $stable(proc_reset_ctl) && $stable(tester_reset_ctl))
        else $error("control output changed without a write");

    a_tester_irq_fwd: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
        (board_in.tester_irq_flag && ctl_ff[6]) |=> host_irq)
        else $error("enabled tester interrupt not forwarded");

    a_proc_irq_fwd: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
        (board_in.proc_host_irq_flag && ctl_ff[5]) |=> host_irq)
        else $error("enabled processor interrupt not forwarded");

    a_irq_blocked: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
        (!(board_in.tester_irq_flag && ctl_ff[6])
            && !(board_in.proc_host_irq_flag && ctl_ff[5])) |=> !host_irq)
        else $error("host interrupt without an enabled source");

    a_ctl_status_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
        s_ctl_read |=> reg_ack && reg_rdata[4] == $past(board_in.tester_ready_flag)
            && reg_rdata[3] == $past(board_in.tester_irq_flag)
            && reg_rdata[2] == $past(board_in.proc_host_irq_flag))
        else $error("control status bits wrong");

    a_reset_ctl_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
        s_ctl_write |=> tester_reset_ctl == $past(reg_wdata[1])
            && proc_reset_ctl == $past(reg_wdata[0]))
        else $error("reset controls do not follow write");

    a_health_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
        s_hlt_read |=> reg_rdata[6] == $past(board_in.core_supply_fault)
            && reg_rdata[4] == $past(board_in.proc_powerdown_flag)
            && reg_rdata[3] == $past(board_in.daughter_line_b)
            && reg_rdata[0] == $past(board_in.indicator_a_state)
            && reg_rdata[7] == 1'b0 && reg_rdata[5] == 1'b0)
        else $error("health readback wrong");

    a_boot_default: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
        $past(sys_rst) |-> soft_boot_ff == 8'h05)
        else $error("soft boot default wrong");

    a_sopt_roundtrip: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
        (reg_req && reg_wr && hit_sopt) ##1 (reg_req && !reg_wr && hit_sopt)
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f))
        else $error("soft option write not read back");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_22
        (rd_req && !(hit_ctl || hit_hlt || hit_sopt || hit_sboot
            || hit_dopt || hit_dboot || hit_aopt)) |=> reg_ack && reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_ack_one_cycle: assert property (@(posedge clk) disable iff (sys_rst) // RULE_21
        reg_req |=> reg_ack ##1 (reg_ack == $past(reg_req)))
        else $error("acknowledge timing wrong");

    a_health_lines: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10 RULE_11
        s_hlt_read |=> reg_rdata[pbc_pkg::HLT_LINE_A_BIT] == $past(board_in.daughter_line_a)
            && reg_rdata[pbc_pkg::HLT_IND_B_BIT] == $past(board_in.indicator_b_state))
        else $error("health line or indicator bit wrong");

    a_rdata_holds: assert property (@(posedge clk) disable iff (sys_rst) // RULE_21
        !rd_req |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_sboot_roundtrip: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
        s_sboot_write ##1 s_sboot_read
            |=> reg_rdata == ($past(reg_wdata, 2) & SBOOT_KEEP))
        else $error("soft boot write not read back");

    a_ro_write_ignored: assert property (@(posedge clk) disable iff (sys_rst) // RULE_22
        (reg_req && reg_wr && !(hit_ctl || hit_sopt || hit_sboot))
            |=> $stable(ctl_ff) && $stable(soft_opt_ff) && $stable(soft_boot_ff))
        else $error("write to a read-only place took effect");

    a_dip_readback: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
        (rd_req && hit_dopt) |=> reg_rdata == {1'b0, $past(dip_opt)})
        else $error("switch option readback wrong");

    a_dip_boot_readback: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
        (rd_req && hit_dboot) |=> reg_rdata == {3'h0, $past(dip_boot)})
        else $error("switch boot readback wrong");

endmodule

`default_nettype wire

// *** sim/tb_pbc_regs.sv ***
// Self-checking bench for the board control register bank
`timescale 1ns/1ns
`default_nettype none

module tb_pbc_regs;
    typedef struct packed {
        logic is_read;
        logic [7:0] value;
    } pbc_note_s;

    logic clk;
    logic sys_rst;
    logic reg_req;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    pbc_pkg::pbc_board_s board_in;
    pbc_pkg::pbc_opt_s dip_opt;
    logic [4:0] dip_boot;
    logic proc_nonmaskable_irq_ctl;
    logic tester_reset_ctl;
    logic proc_reset_ctl;
    logic host_irq;
    pbc_pkg::pbc_opt_s applied_opt;
    logic [4:0] applied_boot;
    int fail_count;
    int checks_done;
    pbc_note_s notes[$];
    pbc_note_s note;
    logic [31:0] r;
    logic [7:0] w;
    logic [7:0] so;
    logic [7:0] sb;
    logic [6:0] sel_opt;
    logic [4:0] sel_boot;

    pbc_regs i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_req(reg_req),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_ack(reg_ack),
        .board_in(board_in),
        .dip_opt(dip_opt),
        .dip_boot(dip_boot),
        .proc_nonmaskable_irq_ctl(proc_nonmaskable_irq_ctl),
        .tester_reset_ctl(tester_reset_ctl),
        .proc_reset_ctl(proc_reset_ctl),
        .host_irq(host_irq),
        .applied_opt(applied_opt),
        .applied_boot(applied_boot)
    );

    always #50 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Holds the request up; idle() drops it
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        reg_req = 1'b1;
        reg_wr = wr;
        reg_addr = addr;
        reg_wdata = data;
        notes.push_back({~wr, data});
        @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        access(1'b1, addr, data);
    endtask

    task automatic rd_reg(input logic [7:0] addr, input logic [7:0] exp);
        access(1'b0, addr, exp);
    endtask

    task automatic idle(input int n);
        reg_req = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] health_exp();
        return {1'b0, board_in.core_supply_fault, 1'b0, board_in.proc_powerdown_flag,
            board_in.daughter_line_b, board_in.daughter_line_a,
            board_in.indicator_b_state, board_in.indicator_a_state};
    endfunction

    function automatic logic [7:0] live_exp();
        return {3'h0, board_in.tester_ready_flag, board_in.tester_irq_flag,
            board_in.proc_host_irq_flag, 2'h0};
    endfunction

    // Read results are matched in issue order
    always @(negedge clk) begin
        if (reg_ack === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("BAD t=%0t acknowledge with no access pending", $time);
            end else begin
                note = notes.pop_front();
                if (note.is_read) begin
                    chk(reg_rdata, note.value, "read data");
                end
            end
        end
    end

    initial begin
        #(3000 * 100);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        reg_req = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        board_in = '0;
        dip_opt = '0;
        dip_boot = 5'h00;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(36220));
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;

        rd_reg(pbc_pkg::OFS_BOARD_CONTROL, 8'h00);
        rd_reg(pbc_pkg::OFS_SOFT_OPTION, 8'h00);
        rd_reg(pbc_pkg::OFS_SOFT_BOOT, 8'h05);
        rd_reg(8'h1c, 8'h00);
        rd_reg(8'h02, 8'h00);
        idle(2);
        chk({5'h0, proc_nonmaskable_irq_ctl, tester_reset_ctl, proc_reset_ctl}, 8'h00,
            "controls after reset");
        $display("test reset values done");

        // All control bits, then bits 7, 1 and 0 each alone, then none, held for several cycles
        for (int k = 0; k < 5; k++) begin
            w = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : (k == 2) ? 8'h02 : (k == 3) ? 8'h01 : 8'h00;
            wr_reg(pbc_pkg::OFS_BOARD_CONTROL, w);
            idle(6);
            chk({5'h0, proc_nonmaskable_irq_ctl, tester_reset_ctl, proc_reset_ctl},
                {5'h0, w[7], w[1], w[0]}, "control outputs");
            rd_reg(pbc_pkg::OFS_BOARD_CONTROL, w & 8'he3);
            idle(1);
        end
        $display("test control bits done");

        // Every enable and source combination
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            w = r[31:24];
            w[6] = i[0];
            w[5] = i[1];
            board_in = pbc_pkg::pbc_board_s'(r[8:0]);
            board_in.tester_irq_flag = i[2];
            board_in.proc_host_irq_flag = i[3];
            wr_reg(pbc_pkg::OFS_BOARD_CONTROL, w);
            rd_reg(pbc_pkg::OFS_BOARD_CONTROL, (w & 8'he3) | live_exp());
            rd_reg(pbc_pkg::OFS_BOARD_HEALTH, health_exp());
            idle(2);
            chk({7'h0, host_irq}, {7'h0, (i[2] & i[0]) | (i[3] & i[1])},
                "host interrupt");
            chk({5'h0, proc_nonmaskable_irq_ctl, tester_reset_ctl, proc_reset_ctl},
                {5'h0, w[7], w[1], w[0]}, "control outputs");
        end
        $display("test interrupts and status done");

        // Switch sources, both selections
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            dip_opt = pbc_pkg::pbc_opt_s'(r[6:0]);
            dip_boot = r[11:7];
            so = r[19:12];
            sb = {i[0], r[26:20]};
            wr_reg(pbc_pkg::OFS_SOFT_OPTION, so);
            rd_reg(pbc_pkg::OFS_SOFT_OPTION, so & 8'h7f);
            wr_reg(pbc_pkg::OFS_SOFT_BOOT, sb);
            rd_reg(pbc_pkg::OFS_SOFT_BOOT, sb & 8'h9f);
            rd_reg(pbc_pkg::OFS_DIP_OPTION, {1'b0, dip_opt});
            rd_reg(pbc_pkg::OFS_DIP_BOOT, {3'h0, dip_boot});
            idle(2);
            sel_opt = i[0] ? so[6:0] : dip_opt;
            sel_boot = i[0] ? sb[4:0] : dip_boot;
            chk({1'b0, applied_opt}, {1'b0, sel_opt ^ 7'h50}, "applied options");
            chk({3'h0, applied_boot}, {3'h0, sel_boot}, "applied boot");
            rd_reg(pbc_pkg::OFS_APPLIED_OPTION, {1'b0, sel_opt ^ 7'h50});
            idle(1);
        end
        $display("test switch sources done");

        // Writes to read-only and unmapped places
        wr_reg(pbc_pkg::OFS_BOARD_HEALTH, 8'hff);
        wr_reg(pbc_pkg::OFS_DIP_OPTION, 8'hff);
        wr_reg(pbc_pkg::OFS_APPLIED_OPTION, 8'hff);
        wr_reg(8'h1c, 8'hff);
        rd_reg(8'h1c, 8'h00);
        rd_reg(pbc_pkg::OFS_BOARD_HEALTH, health_exp());
        rd_reg(pbc_pkg::OFS_SOFT_OPTION, so & 8'h7f);
        rd_reg(pbc_pkg::OFS_SOFT_BOOT, sb & 8'h9f);
        rd_reg(pbc_pkg::OFS_DIP_OPTION, {1'b0, dip_opt});
        rd_reg(pbc_pkg::OFS_APPLIED_OPTION, {1'b0, sel_opt ^ 7'h50});
        idle(3);
        chk(8'(notes.size()), 8'h00, "accesses left without acknowledge");
        $display("test read-only writes done");
        end_sim();
    end
endmodule

`default_nettype wire
